// file: hw/chg_i2c_target.sv
// Serial two-wire target of the charger: register file, paired settings.
// Assumes core_clk far faster than the bus clock; pins are open-drain.
//
// Function
// - Answer only target address 6Bh.
// - Eighth address bit selects write or read.
// - Work at 100 kHz and 400 kHz.
// - Data changes only while clock low.
// - Bus busy from START until STOP.
// - Bytes are eight bits, MSB first, acked.
// - Target may hold clock low to stall; this target never does, scl_oe_q stays 0.
// - Receiver pulls data low for ack.
// - Unknown register address gets NACK, idle.
// - Multi-byte access auto-increments register address.
// - Pair commits both bytes at high write.
// - High byte without low byte is discarded.
// - Pair older than watchdog period is discarded.
// - Read-only maker and part identification registers.
// - Pins only pull low or release.
// - Watchdog period selectable, zero code disables.
`timescale 1ns/10ps
`include "chg_defs.svh"

module chg_i2c_target
  import chg_pkg::*;
#(
  parameter int          TICK_CYCLES = `CHG_CLK_HZ / 1000 * `CHG_TICK_MS,
  parameter logic [17:0] WD1_MS      = 18'(`CHG_WD1_MS),
  parameter logic [17:0] WD2_MS      = 18'(`CHG_WD2_MS),
  parameter logic [17:0] WD3_MS      = 18'(`CHG_WD3_MS),
  parameter logic [7:0]  MAKER_ID    = 8'h5A,  // Arbitrary value
  parameter logic [7:0]  PART_ID     = 8'hA5   // Arbitrary value
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Serial clock pin
  input  wire logic        scl_i,
  output logic             scl_o_q,
  output logic             scl_oe_q,
  // Serial data pin
  input  wire logic        sda_i,
  output logic             sda_o_q,
  output logic             sda_oe_q,
  // Bus state and committed settings
  output logic             busy_q,
  output logic [15:0]      charge_current_setting,
  output logic [15:0]      charge_voltage_setting,
  output logic [15:0]      reverse_output_voltage_setting,
  output logic [15:0]      input_voltage_setting,
  output logic [15:0]      input_current_limit_setting
);

  // ****************************************
  // State
  // ****************************************
  chg_state_t  st_q, st_d;
  logic [2:0]  scl_q, scl_d, sda_q, sda_d;  // [0] first stage, [1] synced, [2] previous
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  rx_q, rx_d, tx_q, tx_d, ptr_q, ptr_d, pend_q, pend_d, rd_byte;
  logic        rw_q, rw_d, hack_q, hack_d, oe_d, busy_d, pend_v_q, pend_v_d;
  logic        lead_q, lead_d;  // Clock fall that closes START still to come
  logic [2:0]  pidx_q, pidx_d;
  logic [15:0] tick_q, tick_d;
  logic [17:0] age_q, age_d, wd_lim;
  logic [7:0]  mem_q [64];
  logic [7:0]  mem_d [64];
  logic        start_ev, stop_ev, rise, fall, wr_ev, ld_rd, expired, pend_ok;
  logic [4:0]  pd;
  logic [1:0]  wd_sel;

  // Pair decode: {is_pair, is_high, index}
  function automatic logic [4:0] pair_dec(input logic [5:0] a);
    logic [4:0] r;
    r = 5'h00;
    if ({a[5:1], 1'b0} == `CHG_CUR_LSB)  r = {1'b1, a[0], 3'h0};
    if ({a[5:1], 1'b0} == `CHG_VOLT_LSB) r = {1'b1, a[0], 3'h1};
    if ({a[5:1], 1'b0} == `CHG_OTGV_LSB) r = {1'b1, a[0], 3'h2};
    if ({a[5:1], 1'b0} == `CHG_VIN_LSB)  r = {1'b1, a[0], 3'h3};
    if ({a[5:1], 1'b0} == `CHG_IIN_LSB)  r = {1'b1, a[0], 3'h4};
    return r;
  endfunction : pair_dec

  // Committed pair values straight from the register file
  assign charge_current_setting         = {mem_q[`CHG_CUR_LSB + 6'h01], mem_q[`CHG_CUR_LSB]};
  assign charge_voltage_setting         = {mem_q[`CHG_VOLT_LSB + 6'h01], mem_q[`CHG_VOLT_LSB]};
  assign reverse_output_voltage_setting = {mem_q[`CHG_OTGV_LSB + 6'h01], mem_q[`CHG_OTGV_LSB]};
  assign input_voltage_setting          = {mem_q[`CHG_VIN_LSB + 6'h01], mem_q[`CHG_VIN_LSB]};
  assign input_current_limit_setting    = {mem_q[`CHG_IIN_LSB + 6'h01], mem_q[`CHG_IIN_LSB]};

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_d = st_q;  bit_d = bit_q;  rx_d = rx_q;  tx_d = tx_q;  ptr_d = ptr_q;
    rw_d = rw_q;  hack_d = hack_q;  oe_d = sda_oe_q;  busy_d = busy_q;  lead_d = lead_q;
    pend_d = pend_q;  pend_v_d = pend_v_q;  pidx_d = pidx_q;
    mem_d = mem_q;
    // Two flops on each pin, third keeps the previous sample
    scl_d = {scl_q[1], scl_q[0], scl_i};
    sda_d = {sda_q[1], sda_q[0], sda_i};
    start_ev = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    stop_ev  = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
    rise     = scl_q[1] && !scl_q[2];
    fall     = !scl_q[1] && scl_q[2];
    wr_ev    = fall && st_q == ST_WDATA && bit_q == 4'h7 && ptr_q <= `CHG_REG_LAST;
    ld_rd    = 1'b0;
    pd       = pair_dec(ptr_q[5:0]);
    // Read source: identification constants, CHG_ID_FILL past CHG_REG_LAST, else committed bytes
    if (ptr_q[5:0] == `CHG_MAKER_REG && ptr_q <= `CHG_REG_LAST) rd_byte = MAKER_ID;
    else if (ptr_q[5:0] == `CHG_PART_REG && ptr_q <= `CHG_REG_LAST) rd_byte = PART_ID;
    else if (ptr_q > `CHG_REG_LAST) rd_byte = `CHG_ID_FILL;
    else rd_byte = mem_q[ptr_q[5:0]];
    // Pair watchdog in millisecond ticks
    wd_sel = mem_q[`CHG_WDT_REG][`CHG_WDT_LSB +: 2];
    unique case (wd_sel)
      2'h1:    wd_lim = WD1_MS;
      2'h2:    wd_lim = WD2_MS;
      2'h3:    wd_lim = WD3_MS;
      default: wd_lim = 18'h3FFFF;
    endcase
    expired = pend_v_q && wd_sel != 2'h0 && age_q >= wd_lim;
    pend_ok = pend_v_q && !expired && pd[4] && pidx_q == pd[2:0];
    tick_d  = (tick_q >= 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_q + 16'h0001;
    age_d   = (pend_v_q && tick_q == 16'h0000 && age_q != 18'h3FFFF) ? age_q + 18'h00001 : age_q;
    if (expired) pend_v_d = 1'b0;
    // Bus protocol
    if (start_ev) begin
      st_d = ST_ADDR;  bit_d = 4'h0;  oe_d = 1'b0;  busy_d = 1'b1;
      lead_d = 1'b1;  // Next clock fall carries no bit
    end else if (stop_ev) begin
      st_d = ST_IDLE;  bit_d = 4'h0;  oe_d = 1'b0;  busy_d = 1'b0;
      lead_d = 1'b0;
    end else if (st_q != ST_IDLE) begin
      if (rise && bit_q < 4'h8) rx_d = {rx_q[6:0], sda_q[1]};
      else if (rise && st_q == ST_RDATA) hack_d = !sda_q[1];
      if (fall && lead_q) begin
        lead_d = 1'b0;  // Fall after START only closes it
      end else if (fall && bit_q < 4'h7) begin
        bit_d = bit_q + 4'h1;
        if (st_q == ST_RDATA) begin
          tx_d = {tx_q[6:0], 1'b0};
          oe_d = !tx_q[6];
        end
      end else if (fall && bit_q == 4'h7) begin
        bit_d = 4'h8;
        oe_d  = 1'b1;
        unique case (st_q)
          ST_ADDR:  if (rx_q[7:1] == `CHG_TGT_ADDR) rw_d = rx_q[0];
                    else begin oe_d = 1'b0; st_d = ST_IDLE; end
          ST_REG:   if (rx_q <= `CHG_REG_LAST) ptr_d = rx_q;
                    else begin oe_d = 1'b0; st_d = ST_IDLE; end
          ST_WDATA: if (!wr_ev) begin oe_d = 1'b0; st_d = ST_IDLE; end
                    else ptr_d = ptr_q + 8'h01;
          ST_RDATA: oe_d = 1'b0;
          default:  oe_d = 1'b0;
        endcase
      end else if (fall) begin
        bit_d = 4'h0;
        oe_d  = 1'b0;
        unique case (st_q)
          ST_ADDR:  if (rw_q) begin st_d = ST_RDATA; ld_rd = 1'b1; end
                    else st_d = ST_REG;
          ST_REG:   st_d = ST_WDATA;
          ST_RDATA: if (hack_q) ld_rd = 1'b1;
                    else st_d = ST_IDLE;
          default:  st_d = st_q;
        endcase
        if (ld_rd) begin
          tx_d  = rd_byte;
          oe_d  = !rd_byte[7];
          ptr_d = ptr_q + 8'h01;
        end
      end
    end
    // Register writes and pair handling
    if (wr_ev) begin
      if (pd[4] && !pd[3]) begin
        pend_d = rx_q;  pend_v_d = 1'b1;  pidx_d = pd[2:0];  age_d = 18'h00000;
      end else begin
        pend_v_d = 1'b0;
        if (pd[4] && pend_ok) begin
          mem_d[{ptr_q[5:1], 1'b0}] = pend_q;
          mem_d[ptr_q[5:0]]         = rx_q;
        end else if (!pd[4] && ptr_q[5:0] != `CHG_MAKER_REG && ptr_q[5:0] != `CHG_PART_REG) begin
          mem_d[ptr_q[5:0]] = rx_q;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= ST_IDLE;  bit_q <= 4'h0;  rx_q <= 8'h00;  tx_q <= 8'h00;  ptr_q <= 8'h00;
      rw_q <= 1'b0;  hack_q <= 1'b0;  sda_oe_q <= 1'b0;  busy_q <= 1'b0;  lead_q <= 1'b0;
      scl_q <= 3'h7;  sda_q <= 3'h7;  pend_q <= 8'h00;  pend_v_q <= 1'b0;  pidx_q <= 3'h0;
      tick_q <= 16'h0000;  age_q <= 18'h00000;
      scl_o_q <= 1'b0;  scl_oe_q <= 1'b0;  sda_o_q <= 1'b0;  // no stretching
      for (int i = 0; i < 64; i++) begin
        mem_q[i] <= (i == `CHG_WDT_REG) ? `CHG_WDT_RST : 8'h00;
      end
    end else begin
      st_q <= st_d;  bit_q <= bit_d;  rx_q <= rx_d;  tx_q <= tx_d;  ptr_q <= ptr_d;
      rw_q <= rw_d;  hack_q <= hack_d;  sda_oe_q <= oe_d;  busy_q <= busy_d;  lead_q <= lead_d;
      scl_q <= scl_d;  sda_q <= sda_d;  pend_q <= pend_d;  pend_v_q <= pend_v_d;
      pidx_q <= pidx_d;  tick_q <= tick_d;  age_q <= age_d;
      scl_o_q <= 1'b0;  scl_oe_q <= 1'b0;  sda_o_q <= 1'b0;
      mem_q <= mem_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  wire [79:0] settings_all = {charge_current_setting, charge_voltage_setting,
    reverse_output_voltage_setting, input_voltage_setting, input_current_limit_setting};

  open_drain_a: assert property (@(posedge core_clk) disable iff (reset)
    !sda_o_q && !scl_o_q && !scl_oe_q) else $error("pin driven high or clock held");
  busy_start_a: assert property (@(posedge core_clk) disable iff (reset)
    start_ev |=> busy_q && st_q == ST_ADDR) else $error("start not tracked");
  busy_stop_a: assert property (@(posedge core_clk) disable iff (reset)
    stop_ev |=> !busy_q && !sda_oe_q) else $error("stop not tracked");
  data_stable_a: assert property (@(posedge core_clk) disable iff (reset)
    $changed(sda_oe_q) && !$past(start_ev) && !$past(stop_ev) |-> !scl_q[1])
    else $error("data moved while clock high");
  addr_nack_a: assert property (@(posedge core_clk) disable iff (reset)
    fall && st_q == ST_ADDR && bit_q == 4'h7 && rx_q[7:1] != `CHG_TGT_ADDR && !start_ev
    |=> !sda_oe_q && st_q == ST_IDLE) else $error("foreign address acked");
  reg_nack_a: assert property (@(posedge core_clk) disable iff (reset)
    fall && st_q == ST_REG && bit_q == 4'h7 && rx_q > `CHG_REG_LAST && !start_ev
    |=> !sda_oe_q && st_q == ST_IDLE) else $error("bad register acked");
  bit_range_a: assert property (@(posedge core_clk) disable iff (reset)
    bit_q <= 4'h8) else $error("bit count out of range");
  lead_skip_a: assert property (@(posedge core_clk) disable iff (reset)
    lead_q && fall && !start_ev |=> bit_q == 4'h0) else $error("start fall counted as bit");
  low_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_ev && pd[4] && !pd[3] |=> $stable(settings_all)) else $error("low byte leaked");
  orphan_high_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_ev && pd[4] && pd[3] && !pend_ok |=> $stable(settings_all) && !pend_v_q)
    else $error("orphan high byte taken");
  wdog_drop_a: assert property (@(posedge core_clk) disable iff (reset)
    expired && !wr_ev |=> !pend_v_q) else $error("stale pair kept");
  maker_read_a: assert property (@(posedge core_clk) disable iff (reset)
    ld_rd && !start_ev && !stop_ev && ptr_q == {2'b00, `CHG_MAKER_REG} |=> tx_q == MAKER_ID)
    else $error("maker code wrong");

endmodule : chg_i2c_target

// file: common/chg_defs.svh
// Constants of the charger serial target: address, register map, timing.
// Assumes inclusion by bare name from the target module.
`ifndef CHG_DEFS_SVH
`define CHG_DEFS_SVH

// ****************************************
// Bus address and register range
// ****************************************
`define CHG_TGT_ADDR   7'h6B
`define CHG_REG_LAST   8'h3F
`define CHG_ID_FILL    8'hFF

// ****************************************
// Two-byte settings, low byte offsets
// ****************************************
`define CHG_CUR_LSB    6'h02
`define CHG_VOLT_LSB   6'h04
`define CHG_OTGV_LSB   6'h06
`define CHG_VIN_LSB    6'h0A
`define CHG_IIN_LSB    6'h24

// ****************************************
// Identification and watchdog field
// ****************************************
`define CHG_MAKER_REG  6'h2E
`define CHG_PART_REG   6'h2F
`define CHG_WDT_REG    6'h01
`define CHG_WDT_LSB    5
`define CHG_WDT_RST    8'h60

// ****************************************
// Timing
// ****************************************
`define CHG_CLK_HZ     50000000
`define CHG_TICK_MS    1
`define CHG_WD1_MS     5000
`define CHG_WD2_MS     88000
`define CHG_WD3_MS     175000

`endif

// file: common/chg_pkg.sv
// Types shared by the charger serial target.
// Assumes chg_defs.svh holds all numeric constants.
package chg_pkg;

  // Protocol phase of the target
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA
  } chg_state_t;

endpackage : chg_pkg

// file: verification/chg_host_model.sv
// Host controller model: drives the serial pins open-drain, 160 ns per bit.
// Assumes the bench resolves pin levels from every pull enable.
`timescale 1ns/10ps
module chg_host_model (
  // Clock and resolved data pin
  input  wire logic core_clk,
  input  wire logic sda_line,
  // Pull-low enables of the pins
  output logic      scl_pull,
  output logic      sda_pull
);
  // ****************************************
  // Pin conditions and bits
  // ****************************************
  // Both pins released at time zero
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // Wait cycles, then step just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  // Start or repeated start, ends with clock low
  task automatic start();
    wt(4);
    sda_pull = 1'b0;
    wt(2);
    scl_pull = 1'b0;
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl_pull = 1'b1;
  endtask : start

  // Stop, leaves the bus free
  task automatic stop();
    wt(2);
    sda_pull = 1'b1;
    wt(2);
    scl_pull = 1'b0;
    wt(4);
    sda_pull = 1'b0;
    wt(4);
  endtask : stop

  // One clock pulse; data set mid-low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_pull = ~b;
    wt(2);
    scl_pull = 1'b0;
    wt(4);
    r = sda_line;
    scl_pull = 1'b1;
  endtask : bit_io

  // Send a byte MSB first, return the target's ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  // Receive a byte; ack when more follow, else NACK
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~more, r);
  endtask : get_byte
endmodule : chg_host_model

// file: verification/tb_chg_i2c_target.sv
// Bench of the charger serial target with a host model on the pins.
// Assumes a 50 MHz core clock and shortened watchdog timebase.
`timescale 1ns/10ps
module tb_chg_i2c_target;
  logic        core_clk;
  logic        reset;
  logic        scl_pull, sda_pull, scl_o_q, scl_oe_q, sda_o_q, sda_oe_q, busy_q;
  logic [15:0] cur_w, volt_w, otgv_w, vin_w, iin_w, rd_w;
  wire         scl_line, sda_line;
  logic        ack;
  int          err_total, tests_run, cycles;

  // Open-drain pins with pull-ups
  assign scl_line = ~(scl_pull | (scl_oe_q & ~scl_o_q));
  assign sda_line = ~(sda_pull | (sda_oe_q & ~sda_o_q));

  chg_i2c_target #(.TICK_CYCLES(10), .WD1_MS(18'h14))
  chg_i2c_target_inst (
    .core_clk(core_clk), .reset(reset), .scl_i(scl_line), .scl_o_q(scl_o_q),
    .scl_oe_q(scl_oe_q), .sda_i(sda_line), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
    .busy_q(busy_q), .charge_current_setting(cur_w), .charge_voltage_setting(volt_w),
    .reverse_output_voltage_setting(otgv_w), .input_voltage_setting(vin_w),
    .input_current_limit_setting(iin_w));

  chg_host_model chg_host_model_inst (
    .core_clk(core_clk), .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));

  // ****************************************
  // Clock, timeout, checks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic wrap_up();
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // ****************************************
  // Transfers
  // ****************************************
  // Write n bytes of d from register r on, every ack expected
  task automatic wr_regs(input logic [7:0] r, input logic [15:0] d, input int n);
    chg_host_model_inst.start();
    chg_host_model_inst.put_byte(8'hD6, ack);
    chk_bit(ack, 1'b1);
    chg_host_model_inst.put_byte(r, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      chg_host_model_inst.put_byte(d[8*i +: 8], ack);
      chk_bit(ack, 1'b1);
    end
    chg_host_model_inst.stop();
  endtask : wr_regs

  // Read registers r and r+1 through a repeated start
  task automatic rd_regs(input logic [7:0] r, input logic [15:0] exp);
    chg_host_model_inst.start();
    chg_host_model_inst.put_byte(8'hD6, ack);
    chg_host_model_inst.put_byte(r, ack);
    chg_host_model_inst.start();
    chg_host_model_inst.put_byte(8'hD7, ack);
    chk_bit(ack, 1'b1);
    chg_host_model_inst.get_byte(1'b1, rd_w[7:0]);
    chg_host_model_inst.get_byte(1'b0, rd_w[15:8]);
    chg_host_model_inst.stop();
    chk_word(rd_w, exp);
  endtask : rd_regs

  // ****************************************
  // Scenarios
  // ****************************************
  // Foreign address refused, busy follows start and stop
  task automatic t_address();
    chg_host_model_inst.start();
    chk_bit(busy_q, 1'b1);
    chg_host_model_inst.put_byte(8'hD4, ack);
    chk_bit(ack, 1'b0);
    chg_host_model_inst.stop();
    chk_bit(busy_q, 1'b0);
    chg_host_model_inst.start();
    chg_host_model_inst.put_byte(8'hD6, ack);
    chg_host_model_inst.put_byte(8'h40, ack);
    chk_bit(ack, 1'b0);
    chg_host_model_inst.stop();
  endtask : t_address

  // Pairs commit whole, never half
  task automatic t_pairs();
    wr_regs(8'h02, 16'h0012, 1);
    chk_word(cur_w, 16'h0000);
    rd_regs(8'h02, 16'h0000);
    wr_regs(8'h03, 16'h0034, 1);
    chk_word(cur_w, 16'h3412);
    wr_regs(8'h04, 16'hBEEF, 2);
    chk_word(volt_w, 16'hBEEF);
    wr_regs(8'h07, 16'h0077, 1);
    chk_word(otgv_w, 16'h0000);
    wr_regs(8'h0A, 16'h0055, 1);
    wr_regs(8'h00, 16'h0000, 1);
    wr_regs(8'h0B, 16'h0066, 1);
    chk_word(vin_w, 16'h0000);
    wr_regs(8'h2E, 16'h2211, 2);
    rd_regs(8'h2E, 16'hA55A);
  endtask : t_pairs

  // Pair timeout with short period, then disabled
  task automatic t_watchdog();
    wr_regs(8'h01, 16'h0020, 1);
    wr_regs(8'h24, 16'h00C3, 1);
    wr_regs(8'h25, 16'h003C, 1);
    chk_word(iin_w, 16'h0000);
    wr_regs(8'h01, 16'h0000, 1);
    wr_regs(8'h24, 16'h00C3, 1);
    chg_host_model_inst.wt(1000);
    wr_regs(8'h25, 16'h003C, 1);
    chk_word(iin_w, 16'h3CC3);
  endtask : t_watchdog

  // Main sequence
  initial begin
    reset = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    reset = 1'b0;
    chg_host_model_inst.wt(4);
    chk_word({11'h000, scl_o_q, scl_oe_q, sda_o_q, sda_oe_q, busy_q}, 16'h0000);
    chk_word(cur_w | volt_w | otgv_w | vin_w | iin_w, 16'h0000);
    rd_regs(8'h00, 16'h6000);
    t_address();
    t_pairs();
    t_watchdog();
    wrap_up();
  end
endmodule : tb_chg_i2c_target
